// file: logic/bspfm_serial_port.sv
// How it works
// - Each received character is stored in the receive buffer at once unless the buffer is full.
// - Software reads one character, each flagged when it is the terminator.
// - Characters waiting while the transmitter idles start transmission by themselves.
// - Transmit interrupt enable drops after the last buffered character is sent.
// - With echo on, every received character is queued for retransmission if the transmit buffer has room.
// - With flow control, request-to-send rises at 80 percent receive fill.
// - Request-to-send falls only when fill is below 20 percent.
// - Port one has no request-to-send or clear-to-send lines.
// - Port zero is RS-232 only; port one may run RS-485.
// - XMODEM transfers whole 128-byte blocks; a block counter tracks this.
// - Echo is suspended while an XMODEM transfer runs.
// - With modem option, characters read out are scanned for modem messages.
// - Command mode until a link message, then data mode.
// - In data mode the carrier-lost message is still watched.
// - Modem messages end at carriage return.
// - In modem mode clear-to-send is ignored.
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module bspfm_serial_port
  import bspfm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd0,
  input wire logic cts0,
  output logic txd0,
  output logic rts0,
  input wire logic rxd1,
  output logic txd1,
  output logic de1
);
  // ********************************
  // Reset release and state
  // ********************************
  logic [1:0] rstPipe;
  logic rstn;
  bspfm_state_type st;
  bspfm_state_type next_st;
  logic [7:0] rxMem [DEPTH];
  logic [7:0] txMem [DEPTH];
  logic rxDone, rxPush, rxPop, txPush, txPop, echoPush, hostPush;
  logic [7:0] txData, popChar;
  logic rxIn, ctsIn, ctsOk, apbSetup, apbAcc, mapped, collide;

  // Two-stage release so every state flop leaves reset on the same edge
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstn = rstPipe[1];

  // Message byte at a given position, left to right
  function automatic logic [7:0] msgChar(input logic [79:0] msg, input logic [3:0] idx);
    msgChar = msg[79 - 8 * idx -: 8];
  endfunction : msgChar

  // Fill step for a circular buffer with one writer and one reader
  function automatic logic [PTR_W:0] fillStep(input logic [PTR_W:0] f, input logic inc,
                                             input logic dec);
    fillStep = f + {{PTR_W{1'b0}}, inc} - {{PTR_W{1'b0}}, dec};
  endfunction : fillStep

  // ********************************
  // Pin routing
  // ********************************
  assign rxIn = st.ctrl[C_PORT1] ? st.syncB[2] : st.syncB[0];
  assign ctsIn = st.syncB[1];
  // Modem mode and port one do not look at the handshake line
  assign ctsOk = st.ctrl[C_PORT1] | st.ctrl[C_MODEM] | ~ctsIn;
  assign txd0 = st.ctrl[C_PORT1] ? 1'b1 : st.txLine;
  assign txd1 = st.ctrl[C_PORT1] ? st.txLine : 1'b1;
  assign de1 = st.ctrl[C_PORT1] & st.ctrl[C_RS485] & (st.txSt != LN_IDLE);
  assign rts0 = st.rts;
  assign prdata = st.prdata;

  // ********************************
  // APB decode
  // ********************************
  assign apbSetup = psel & ~penable;
  assign apbAcc = psel & penable;
  assign mapped = (paddr == ADDR_CTRL) | (paddr == ADDR_DIV) | (paddr == ADDR_TXD) |
                  (paddr == ADDR_RXD) | (paddr == ADDR_STAT);
  // A host write loses to an echo in the same cycle; the wait is one cycle
  assign collide = apbAcc & pwrite & (paddr == ADDR_TXD) & echoPush;
  assign pready = ~collide;
  assign pslverr = apbAcc & ~mapped;
  assign popChar = rxMem[st.rxRd];

  // ********************************
  // Next state
  // ********************************
  always_comb begin
    next_st = st;
    rxDone = 1'b0;
    rxPush = 1'b0;
    rxPop = 1'b0;
    txPop = 1'b0;
    echoPush = 1'b0;
    hostPush = 1'b0;
    // Pins pass two flops before use
    next_st.syncA = {rxd1, cts0, rxd0};
    next_st.syncB = st.syncA;
    // Read data captured in setup so it is stable through the access
    if (apbSetup && !pwrite) begin
      unique case (paddr)
        ADDR_CTRL: next_st.prdata = {16'h0000, st.term, 2'b00, st.ctrl};
        ADDR_DIV: next_st.prdata = {16'h0000, st.div};
        ADDR_RXD: next_st.prdata = {22'h000000, st.rxFill != '0,
                                    popChar == st.term, popChar};
        ADDR_STAT: next_st.prdata = {3'b000, st.lineCount, 2'b00, st.xCount == '0,
                                     st.txSt != LN_IDLE, st.dataMode, st.txIntEn,
                                     st.overrun, st.rts, 3'b000, st.txFill,
                                     3'b000, st.rxFill};
        default: next_st.prdata = 32'h00000000;
      endcase
    end
    // Register writes; hardware events below override the clear
    if (apbAcc && pwrite) begin
      unique case (paddr)
        ADDR_CTRL: begin
          next_st.ctrl = pwdata[5:0];
          next_st.term = pwdata[15:8];
        end
        ADDR_DIV: next_st.div = pwdata[15:0];
        ADDR_STAT: if (pwdata[S_OVERRUN]) next_st.overrun = 1'b0;
        default: ;
      endcase
    end
    // Receiver: half-bit wait, then sample mid bit
    unique case (st.rxSt)
      LN_IDLE: begin
        if (!rxIn) begin
          next_st.rxSt = LN_START;
          next_st.rxCnt = st.div >> 1;
        end
      end
      LN_START: begin
        if (st.rxCnt != '0) begin
          next_st.rxCnt = st.rxCnt - 16'h0001;
        end else if (rxIn) begin
          next_st.rxSt = LN_IDLE; // Glitch, not a start bit
        end else begin
          next_st.rxSt = LN_DATA;
          next_st.rxCnt = st.div;
          next_st.rxBit = 3'h0;
        end
      end
      LN_DATA: begin
        if (st.rxCnt != '0) begin
          next_st.rxCnt = st.rxCnt - 16'h0001;
        end else begin
          next_st.rxShift = {rxIn, st.rxShift[7:1]};
          next_st.rxCnt = st.div;
          next_st.rxBit = st.rxBit + 3'h1;
          if (st.rxBit == 3'h7) next_st.rxSt = LN_STOP;
        end
      end
      LN_STOP: begin
        if (st.rxCnt != '0) begin
          next_st.rxCnt = st.rxCnt - 16'h0001;
        end else begin
          next_st.rxSt = LN_IDLE;
          rxDone = rxIn; // Framing errors are dropped
        end
      end
    endcase
    // Store or drop the finished character
    if (rxDone) begin
      if (st.rxFill == FILL_FULL) begin
        next_st.overrun = 1'b1;
      end else begin
        rxPush = 1'b1;
      end
      if (st.ctrl[C_XMODEM]) begin
        next_st.xCount = st.xCount + 7'h01;
      end
      echoPush = st.ctrl[C_ECHO] & ~st.ctrl[C_XMODEM] &
                 (st.txFill != FILL_FULL);
    end
    if (!st.ctrl[C_XMODEM]) next_st.xCount = 7'h00;
    hostPush = apbAcc & pwrite & (paddr == ADDR_TXD) & ~collide &
               (st.txFill != FILL_FULL);
    txPush = echoPush | hostPush;
    txData = echoPush ? st.rxShift : pwdata[7:0];
    if (rxPush) begin
      next_st.rxWr = st.rxWr + 1'b1;
    end
    // Pop only what setup reported valid; a late arrival waits for the next read
    rxPop = apbAcc & ~pwrite & (paddr == ADDR_RXD) & st.prdata[9];
    if (rxPop) begin
      next_st.rxRd = st.rxRd + 1'b1;
    end
    next_st.lineCount = fillStep(st.lineCount, rxPush && st.rxShift == st.term,
                                 rxPop && popChar == st.term);
    // Modem scan on characters read out, both messages at once
    if (rxPop && st.ctrl[C_MODEM]) begin
      if (popChar == CHAR_CR) begin
        if (st.okLink && st.idxLink == LEN_LINK) next_st.dataMode = 1'b1;
        if (st.okLost && st.idxLost == LEN_LOST) next_st.dataMode = 1'b0;
        next_st.idxLink = 4'h0;
        next_st.idxLost = 4'h0;
        next_st.okLink = 1'b1;
        next_st.okLost = 1'b1;
      end else begin
        next_st.okLink = st.okLink & (st.idxLink < LEN_LINK) &
                         (popChar == msgChar(MSG_LINK, st.idxLink));
        next_st.okLost = st.okLost & (st.idxLost < LEN_LOST) &
                         (popChar == msgChar(MSG_LOST, st.idxLost));
        if (st.idxLink != 4'hF) next_st.idxLink = st.idxLink + 4'h1;
        if (st.idxLost != 4'hF) next_st.idxLost = st.idxLost + 4'h1;
      end
    end
    if (!st.ctrl[C_MODEM]) next_st.dataMode = 1'b0;
    // Transmitter
    unique case (st.txSt)
      LN_IDLE: begin
        if (st.txFill != '0 && ctsOk) begin
          txPop = 1'b1;
          next_st.txShift = txMem[st.txRd];
          next_st.txSt = LN_START;
          next_st.txCnt = st.div;
          next_st.txLine = 1'b0;
        end
      end
      LN_START: begin
        if (st.txCnt != '0) begin
          next_st.txCnt = st.txCnt - 16'h0001;
        end else begin
          next_st.txSt = LN_DATA;
          next_st.txCnt = st.div;
          next_st.txBit = 3'h0;
          next_st.txLine = st.txShift[0];
        end
      end
      LN_DATA: begin
        if (st.txCnt != '0) begin
          next_st.txCnt = st.txCnt - 16'h0001;
        end else begin
          next_st.txCnt = st.div;
          next_st.txBit = st.txBit + 3'h1;
          next_st.txShift = st.txShift >> 1;
          next_st.txLine = st.txShift[1];
          if (st.txBit == 3'h7) begin
            next_st.txSt = LN_STOP;
            next_st.txLine = 1'b1;
          end
        end
      end
      LN_STOP: begin
        if (st.txCnt != '0) begin
          next_st.txCnt = st.txCnt - 16'h0001;
        end else begin
          next_st.txSt = LN_IDLE;
          if (st.txFill == '0 && !txPush) next_st.txIntEn = 1'b0;
        end
      end
    endcase
    if (txPush) begin
      next_st.txWr = st.txWr + 1'b1;
      next_st.txIntEn = 1'b1;
    end
    if (txPop) begin
      next_st.txRd = st.txRd + 1'b1;
    end
    next_st.rxFill = fillStep(st.rxFill, rxPush, rxPop);
    next_st.txFill = fillStep(st.txFill, txPush, txPop);
    // Hysteresis keeps the line from chattering near one threshold
    if (!st.ctrl[C_FLOW] || st.ctrl[C_PORT1]) begin
      next_st.rts = 1'b0;
    end else if (st.rxFill >= FILL_HI) begin
      next_st.rts = 1'b1;
    end else if (st.rxFill < FILL_LO) begin
      next_st.rts = 1'b0;
    end
  end

  // ********************************
  // Registers and buffers
  // ********************************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Buffer storage needs no reset; fill counts guard stale words
  always_ff @(posedge ref_clk) begin
    if (rxPush) rxMem[st.rxWr] <= st.rxShift;
    if (txPush) txMem[st.txWr] <= txData;
  end

  // ********************************
  // Checks
  // ********************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence seqFrameEnd;
    st.rxSt == LN_STOP && st.rxCnt == '0 && rxIn;
  endsequence
  sequence seqLinkLine;
    rxPop && st.ctrl[C_MODEM] && popChar == CHAR_CR && st.okLink &&
      st.idxLink == LEN_LINK && !(st.okLost && st.idxLost == LEN_LOST);
  endsequence
  sequence seqLostLine;
    rxPop && st.ctrl[C_MODEM] && popChar == CHAR_CR && st.okLost &&
      st.idxLost == LEN_LOST;
  endsequence

  chk_rx_store: assert property (seqFrameEnd ##0 (st.rxFill != FILL_FULL && !rxPop)
    |=> st.rxFill == $past(st.rxFill) + 1'b1)
    else $error("received character not stored");
  chk_rx_full_drop: assert property (seqFrameEnd ##0 (st.rxFill == FILL_FULL && !rxPop)
    |=> st.overrun && st.rxFill == FILL_FULL)
    else $error("full buffer not protected");
  chk_tx_autostart: assert property ((st.txSt == LN_IDLE && st.txFill != '0 && ctsOk)
    |=> st.txSt == LN_START && !st.txLine ##1 st.txSt == LN_START)
    else $error("transmit did not start");
  chk_cts_gate: assert property ((st.txSt == LN_IDLE && !st.ctrl[C_PORT1] &&
    !st.ctrl[C_MODEM] && ctsIn) |=> st.txSt == LN_IDLE)
    else $error("sent while clear-to-send high");
  chk_txint_off: assert property ((st.txSt == LN_STOP && st.txCnt == '0 &&
    st.txFill == '0 && !txPush) |=> !st.txIntEn && st.txLine)
    else $error("transmit interrupt left on");
  chk_echo_push: assert property ((seqFrameEnd ##0 (st.ctrl[C_ECHO] &&
    !st.ctrl[C_XMODEM] && st.txFill != FILL_FULL)) |-> echoPush ##1 st.txIntEn)
    else $error("echo missing");
  chk_xmodem_noecho: assert property (st.ctrl[C_XMODEM] |-> !echoPush)
    else $error("echo during block transfer");
  chk_rts_high: assert property ((st.ctrl[C_FLOW] && !st.ctrl[C_PORT1] &&
    st.rxFill >= FILL_HI) |=> rts0)
    else $error("request-to-send not raised");
  chk_rts_hold: assert property ((rts0 && st.ctrl[C_FLOW] && !st.ctrl[C_PORT1] &&
    st.rxFill >= FILL_LO) |=> $stable(rts0))
    else $error("request-to-send dropped early");
  chk_port1_pins: assert property (st.ctrl[C_PORT1] |-> txd0 ##1 !rts0)
    else $error("port one drove handshake");
  chk_de_zero: assert property (!st.ctrl[C_PORT1] |-> !de1 && txd1)
    else $error("driver enabled for port zero");
  chk_modem_link: assert property (seqLinkLine |=> st.dataMode)
    else $error("link message ignored");
  chk_modem_lost: assert property (seqLostLine |=> !st.dataMode)
    else $error("carrier loss ignored");
  chk_xblock: assert property ((rxDone && st.ctrl[C_XMODEM] &&
    st.xCount == XBLOCK_LAST) |=> st.xCount == '0)
    else $error("block count wrong");
endmodule : bspfm_serial_port
`default_nettype wire

// file: shared/bspfm_pkg.sv
package bspfm_pkg;
  // ********************************
  // Sizes and offsets
  // ********************************
  localparam int PTR_W = 4;
  localparam int DEPTH = 16;
  localparam logic [PTR_W:0] FILL_FULL = 5'h10;
  // Thresholds in percent of capacity, rounded up to whole characters
  localparam int HI_PCT = 80;
  localparam int LO_PCT = 20;
  localparam logic [PTR_W:0] FILL_HI = (PTR_W+1)'((DEPTH * HI_PCT + 99) / 100);
  localparam logic [PTR_W:0] FILL_LO = (PTR_W+1)'((DEPTH * LO_PCT + 99) / 100);
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_DIV = 12'h004;
  localparam logic [11:0] ADDR_TXD = 12'h008;
  localparam logic [11:0] ADDR_RXD = 12'h00C;
  localparam logic [11:0] ADDR_STAT = 12'h010;
  // Control field positions
  localparam int C_ECHO = 0;
  localparam int C_FLOW = 1;
  localparam int C_MODEM = 2;
  localparam int C_XMODEM = 3;
  localparam int C_PORT1 = 4;
  localparam int C_RS485 = 5;
  localparam int S_OVERRUN = 17;
  localparam logic [15:0] DIV_RESET = 16'h00AE;
  localparam logic [7:0] TERM_RESET = 8'h0D;
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [6:0] XBLOCK_LAST = 7'h7F;
  // Modem messages, left aligned, space padded
  localparam logic [79:0] MSG_LINK = "CONNECT   ";
  localparam logic [3:0] LEN_LINK = 4'h7;
  localparam logic [79:0] MSG_LOST = "NO CARRIER";
  localparam logic [3:0] LEN_LOST = 4'hA;

  // ********************************
  // Types
  // ********************************
  typedef enum logic [1:0] {
    LN_IDLE = 2'b00,
    LN_START = 2'b01,
    LN_DATA = 2'b10,
    LN_STOP = 2'b11
  } bspfm_line_type;

  typedef struct packed {
    logic [2:0] syncA;
    logic [2:0] syncB;
    logic [5:0] ctrl;
    logic [7:0] term;
    logic [15:0] div;
    bspfm_line_type rxSt;
    logic [15:0] rxCnt;
    logic [2:0] rxBit;
    logic [7:0] rxShift;
    bspfm_line_type txSt;
    logic [15:0] txCnt;
    logic [2:0] txBit;
    logic [7:0] txShift;
    logic txLine;
    logic [PTR_W-1:0] rxWr;
    logic [PTR_W-1:0] rxRd;
    logic [PTR_W:0] rxFill;
    logic [PTR_W-1:0] txWr;
    logic [PTR_W-1:0] txRd;
    logic [PTR_W:0] txFill;
    logic [PTR_W:0] lineCount;
    logic rts;
    logic overrun;
    logic txIntEn;
    logic dataMode;
    logic [6:0] xCount;
    logic [3:0] idxLink;
    logic [3:0] idxLost;
    logic okLink;
    logic okLost;
    logic [31:0] prdata;
  } bspfm_state_type;

  localparam bspfm_state_type ST_RESET = '{
    syncA: 3'h7, syncB: 3'h7, term: TERM_RESET, div: DIV_RESET,
    rxSt: LN_IDLE, txSt: LN_IDLE, txLine: 1'b1, okLink: 1'b1, okLost: 1'b1,
    default: '0};
endpackage : bspfm_pkg

// file: verification/bspfm_peer.sv
`timescale 1ns/1ps
`default_nettype none
module bspfm_peer #(
  parameter int BIT = 8
) (
  input wire logic ref_clk,
  input wire logic serIn,
  input wire logic stopReq,
  input wire logic obey,
  output logic serOut
);
  logic [7:0] rxq[$];
  logic [7:0] got;

  // ********************************
  // Sender
  // ********************************
  initial serOut = 1'b1;

  // Start bit, eight data bits LSB first, stop bit; line idles high
  task automatic sendByte(input logic [7:0] b);
    int n;
    // Pause while the device asks us to stop
    for (n = 0; n < 5000 && obey && stopReq; n++) @(posedge ref_clk);
    for (int i = 0; i < 10; i++) begin
      serOut <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
      repeat (BIT) @(posedge ref_clk);
    end
  endtask : sendByte

  // ********************************
  // Receiver
  // ********************************
  // Mid-bit sampling; a bad stop bit drops the character like real hardware
  initial begin
    forever begin
      @(negedge serIn);
      repeat (BIT / 2) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge ref_clk);
        got[i] = serIn;
      end
      repeat (BIT) @(posedge ref_clk);
      if (serIn) rxq.push_back(got);
    end
  end
endmodule : bspfm_peer
`default_nettype wire

// file: verification/buffered_serial_port_flow_modem_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin failCount++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module buffered_serial_port_flow_modem_bench
  import bspfm_pkg::*;
;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic cts0 = 1'b0; // Attached equipment holds it low
  logic toOne = 1'b0;
  logic obey = 1'b1;
  logic [31:0] prdata, rq;
  logic [31:0] seed = 32'h47;
  logic pready, pslverr, txd0, rts0, txd1, de1, re, peerOut, de1Seen, txd0Low;
  int failCount = 0;
  int numChecks = 0;
  logic [7:0] msg[$];

  // Free-running clock, 50 ns period
  always #25 ref_clk = ~ref_clk;

  bspfm_serial_port dut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd0(peerOut), .cts0(cts0), .txd0(txd0), .rts0(rts0),
    .rxd1(peerOut), .txd1(txd1), .de1(de1));

  bspfm_peer #(.BIT(8)) peer (.ref_clk(ref_clk), .serIn(toOne ? txd1 : txd0),
    .stopReq(rts0), .obey(obey), .serOut(peerOut));

  // ********************************
  // Helpers
  // ********************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Expected receive word: valid flag plus terminator flag
  function automatic logic [31:0] rxWord(input logic [7:0] c);
    return {22'h0, 1'b1, c == TERM_RESET, c};
  endfunction : rxWord

  // Request held until pready is seen; idle cycle after so no double drive
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    if (n == 50) begin
      failCount++;
      summarize();
    end
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // Random bytes, carriage return kept out so flags stay predictable
  task automatic fill(input int n);
    logic [7:0] b;
    repeat (n) begin
      b = 8'(xs());
      msg.push_back(b == CHAR_CR ? 8'h5A : b);
    end
  endtask : fill

  task automatic msgStr(input string s);
    msg.delete();
    foreach (s[i]) msg.push_back(s[i]);
    msg.push_back(CHAR_CR);
  endtask : msgStr

  task automatic sendMsg();
    foreach (msg[i]) peer.sendByte(msg[i]);
    repeat (20) @(posedge ref_clk);
  endtask : sendMsg

  task automatic readRange(input int lo, input int hi);
    for (int i = lo; i < hi; i++) begin
      rd(ADDR_RXD);
      `CHK("rx word", rxWord(msg[i]), rq)
    end
  endtask : readRange

  // Bounded wait for characters at the peer, watching port pins meanwhile
  task automatic waitPeer(input int n);
    int k;
    for (k = 0; k < 3000 && peer.rxq.size() < n; k++) begin
      @(posedge ref_clk);
      if (de1 === 1'b1) de1Seen = 1'b1;
      if (txd0 === 1'b0) txd0Low = 1'b1;
    end
    if (k == 3000) begin
      failCount++;
      summarize();
    end
  endtask : waitPeer

  task automatic summarize();
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  // ********************************
  // Scenarios
  // ********************************
  initial begin
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(ADDR_CTRL);
    `CHK("ctrl reset", 32'h00000D00, rq)
    rd(ADDR_DIV);
    `CHK("div reset", {16'h0, DIV_RESET}, rq)
    rd(ADDR_STAT);
    `CHK("stat reset", 32'h00200000, rq)
    `CHK("idle line", 1'b1, txd0)
    rd(12'h014);
    `CHK("unmapped err", 1'b1, re)
    $display("reset test done");
    wr(ADDR_DIV, 32'h7);
    msg.delete();
    fill(4);
    foreach (msg[i]) wr(ADDR_TXD, {24'h0, msg[i]});
    rd(ADDR_STAT);
    `CHK("tx irq on", 1'b1, rq[18])
    waitPeer(4);
    foreach (msg[i]) `CHK("tx char", msg[i], peer.rxq[i])
    repeat (20) @(posedge ref_clk);
    rd(ADDR_STAT);
    `CHK("tx irq off", 1'b0, rq[18])
    $display("transmit test done");
    msg.delete();
    fill(5);
    msg.push_back(CHAR_CR);
    sendMsg();
    rd(ADDR_STAT);
    `CHK("rx fill", 5'h06, rq[4:0])
    `CHK("term count", 5'h01, rq[28:24])
    readRange(0, 6);
    rd(ADDR_RXD);
    `CHK("empty valid", 1'b0, rq[9])
    $display("receive test done");
    wr(ADDR_CTRL, 32'h0D01);
    peer.rxq.delete();
    msg.delete();
    fill(1);
    sendMsg();
    waitPeer(1);
    `CHK("echo", msg[0], peer.rxq[0])
    readRange(0, 1);
    wr(ADDR_CTRL, 32'h0D09);
    peer.rxq.delete();
    sendMsg();
    repeat (150) @(posedge ref_clk);
    `CHK("echo paused", 0, peer.rxq.size())
    readRange(0, 1);
    rd(ADDR_STAT);
    `CHK("block mid", 1'b0, rq[21])
    msg.delete();
    fill(127);
    sendMsg();
    rd(ADDR_STAT);
    `CHK("block edge", 1'b1, rq[21])
    `CHK("block full", FILL_FULL, rq[4:0])
    readRange(0, 16);
    wr(ADDR_STAT, 32'h00020000);
    rd(ADDR_STAT);
    `CHK("overrun clear", 1'b0, rq[17])
    $display("echo test done");
    wr(ADDR_CTRL, 32'h0D02);
    msg.delete();
    fill(13);
    for (int i = 0; i < 12; i++) peer.sendByte(msg[i]);
    repeat (20) @(posedge ref_clk);
    `CHK("rts at 12", 1'b0, rts0)
    peer.sendByte(msg[12]);
    repeat (20) @(posedge ref_clk);
    `CHK("rts at 13", 1'b1, rts0)
    readRange(0, 9);
    `CHK("rts at 4", 1'b1, rts0)
    readRange(9, 10);
    // The drop lands on the read's last edge; look one edge later once it has settled
    @(posedge ref_clk);
    `CHK("rts at 3", 1'b0, rts0)
    readRange(10, 13);
    $display("flow test done");
    wr(ADDR_CTRL, 32'h0D00);
    msg.delete();
    fill(17);
    sendMsg();
    rd(ADDR_STAT);
    `CHK("full fill", FILL_FULL, rq[4:0])
    `CHK("overrun", 1'b1, rq[17])
    readRange(0, 16);
    $display("overrun test done");
    wr(ADDR_CTRL, 32'h0D04); // CR terminator is no command letter
    msgStr("CONNECT");
    sendMsg();
    rd(ADDR_STAT);
    `CHK("unread mode", 1'b0, rq[19])
    readRange(0, 8);
    rd(ADDR_STAT);
    `CHK("data mode", 1'b1, rq[19])
    cts0 <= 1'b1;
    peer.rxq.delete();
    wr(ADDR_TXD, 32'hA5);
    waitPeer(1);
    `CHK("cts ignored", 8'hA5, peer.rxq[0])
    msgStr("NO CARRIER");
    sendMsg();
    readRange(0, 11);
    rd(ADDR_STAT);
    `CHK("carrier lost", 1'b0, rq[19])
    $display("modem test done");
    wr(ADDR_CTRL, 32'h0D00);
    peer.rxq.delete();
    wr(ADDR_TXD, 32'h3C);
    repeat (150) @(posedge ref_clk);
    `CHK("cts holds", 0, peer.rxq.size())
    cts0 <= 1'b0;
    waitPeer(1);
    `CHK("cts release", 8'h3C, peer.rxq[0])
    $display("cts test done");
    wr(ADDR_CTRL, 32'h0D32);
    toOne = 1'b1;
    de1Seen = 1'b0;
    txd0Low = 1'b0;
    peer.rxq.delete();
    wr(ADDR_TXD, 32'hC3);
    waitPeer(1);
    `CHK("port one char", 8'hC3, peer.rxq[0])
    `CHK("driver enable", 1'b1, de1Seen)
    `CHK("port zero quiet", 1'b0, txd0Low)
    msg.delete();
    fill(13);
    sendMsg();
    `CHK("no rts on one", 1'b0, rts0)
    readRange(0, 13);
    $display("port one test done");
    summarize();
  end

  // Watchdog for any hang
  initial begin
    repeat (100000) @(posedge ref_clk);
    failCount++;
    summarize();
  end
endmodule : buffered_serial_port_flow_modem_bench
`default_nettype wire
